// ---- core/timed_io_pkg.sv ----
// Constants for the timed I/O port unit: map, fields, widths, timing.
// Assumes a single 250 MHz system clock and an Avalon-MM register master.
package timed_io_pkg;
  // Structure
  localparam int NUM_PORTS = 5;
  localparam int NUM_CB = 6;
  localparam int PIN_W = 32;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int PORT_W [NUM_PORTS] = '{1, 4, 8, 16, 32};
  localparam int LINK_PIN_LO = 16;
  localparam int CHUNK_W = 6;
  // Clock block 0 rate, made from the system clock by a fractional step
  localparam int SYS_CLK_MHZ = 250;
  localparam int REF_CLK_MHZ = 100;
  localparam logic [8:0] REF_ACC_STEP = 9'(REF_CLK_MHZ);
  localparam logic [8:0] REF_ACC_MOD = 9'(SYS_CLK_MHZ);
  // Global register map, byte addresses
  localparam logic [7:0] ADDR_GLOBAL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_CB_BASE = 8'h10;
  localparam logic [7:0] ADDR_CB_FIRST = 8'h14;
  localparam logic [7:0] ADDR_CB_LAST = 8'h24;
  localparam logic [7:0] ADDR_PORT_BASE = 8'h40;
  // Per-port register offsets inside a 32-byte slot
  localparam logic [4:0] POFF_CTRL = 5'h00;
  localparam logic [4:0] POFF_DATA = 5'h04;
  localparam logic [4:0] POFF_TIME = 5'h08;
  localparam logic [4:0] POFF_COND = 5'h0c;
  localparam logic [4:0] POFF_COUNT = 5'h10;
  localparam logic [4:0] POFF_TSTAMP = 5'h14;
  localparam logic [4:0] POFF_STAT = 5'h18;
  // Port control fields
  localparam int CTRL_W = 11;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIR_OUT = 1;
  localparam int CTRL_OD = 2;
  localparam int CTRL_CB_LSB = 3;
  localparam int CB_SEL_W = 3;
  localparam int CTRL_TIMED = 6;
  localparam int CTRL_COND_EN = 7;
  localparam int CTRL_COND_NEQ = 8;
  localparam int CTRL_STB_IN = 9;
  localparam int CTRL_STB_OUT = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  // Port status fields
  localparam int STAT_FULL = 0;
  localparam int STAT_BUSY = 1;
  // Global and clock block fields
  localparam int GLB_LINK_EN = 0;
  localparam int CB_CFG_W = 9;
  localparam int CB_SRC_EXT = 8;
  localparam logic [CB_CFG_W-1:0] CB_CFG_RST = 9'h000;
  typedef enum logic {PS_IDLE, PS_SHIFT} port_state_e;
endpackage

// ---- core/timed_io_port_unit.sv ----
// Timed I/O port unit: five ports of 1..32 bits, six clock blocks, pin mux.
// Assumes an Avalon-MM master on sys_clk and asynchronous pins and strobes.
// Function
// - Ports of widths 1, 4, 8, 16, 32
// - All pins of a port share direction
// - Drive pins, or sample with optional condition
// - Each processor access completes in two cycles, one wait state
// - Open-drain per port: zero drives, one floats
// - Shift register plus transfer register buffer data
// - 16-bit counter gates the transfer moment
// - Counter readable at any time
// - Counter captured as timestamp each transfer
// - Enabled link takes shared pins from ports
// - Narrower enabled port overrides wider port
// - Unshared pins stay with the wider port
// - Ports always transfer at nominal width
// - Six clock blocks, block 0 at reference rate
// - Blocks 1 to 5 have own frequency
// - Block may run from divided 1-bit pin
// - Accept incoming strobe, generate outgoing strobe
// - After reset all ports use block 0
module timed_io_port_unit import timed_io_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins
  input wire logic [PIN_W-1:0] pin_in,
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe,
  // Strobes, one per port
  input wire logic [NUM_PORTS-1:0] incoming_valid_strobe,
  output logic [NUM_PORTS-1:0] outgoing_valid_strobe,
  // Interrupt
  output logic irq
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction

  // Bus slave state
  logic wait_ff;
  logic req, accept, wr_acc, rd_acc, port_hit, cb_hit;
  logic [31:0] readdata_ff, rd_mux, be_mask, wd_be;
  logic [7:0] a_rel, c_rel;
  logic [2:0] a_port, cb_idx;
  logic [4:0] a_off;

  // Global state
  logic link_en_ff;
  logic irq_ff;
  logic [NUM_PORTS-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat, irq_clr;

  // Synchronisers
  logic [PIN_W-1:0] pin_meta_ff, pin_sync_ff;
  logic ext_prev_ff;
  logic [NUM_PORTS-1:0] stb_meta_ff, stb_sync_ff;

  // Clock blocks
  logic [NUM_CB-1:0] cb_tick_ff;
  logic [7:0] cb_tick;
  logic [CB_CFG_W-1:0] cb_cfg_ff [NUM_CB];
  logic ext_rise;

  // Ports
  logic [CTRL_W-1:0] ctrl_ff [NUM_PORTS];
  logic [DATA_W-1:0] tx_ff [NUM_PORTS], shift_ff [NUM_PORTS], cond_ff [NUM_PORTS];
  logic [CNT_W-1:0] count_ff [NUM_PORTS], time_ff [NUM_PORTS], tstamp_ff [NUM_PORTS];
  logic [CHUNK_W-1:0] chunk_ff [NUM_PORTS];
  port_state_e pstate_ff [NUM_PORTS];
  logic [NUM_PORTS-1:0] tx_full_ff, strobe_ff, port_evt, port_en;
  logic [PIN_W-1:0] drive_val [NUM_PORTS], drive_oe [NUM_PORTS], port_od_mask [NUM_PORTS];

  // Pin mux
  logic [PIN_W-1:0] pin_out_ff, pin_oe_ff, nxt_pin_out, nxt_pin_oe, od_mask;

  // Decode
  assign req = avs_read | avs_write;
  assign accept = req & ~wait_ff;
  assign wr_acc = accept & avs_write;
  assign rd_acc = accept & avs_read;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd_be = avs_writedata & be_mask;
  assign a_rel = avs_address - ADDR_PORT_BASE;
  assign a_port = a_rel[7:5];
  assign a_off = a_rel[4:0];
  assign port_hit = (avs_address >= ADDR_PORT_BASE) && (a_port < 3'(NUM_PORTS))
                    && (a_off <= POFF_STAT) && (a_off[1:0] == 2'b00);
  assign c_rel = avs_address - ADDR_CB_BASE;
  assign cb_idx = c_rel[4:2];
  assign cb_hit = (avs_address >= ADDR_CB_FIRST) && (avs_address <= ADDR_CB_LAST)
                  && (avs_address[1:0] == 2'b00);
  assign irq_clr = (wr_acc && avs_address == ADDR_IRQ_STATUS) ?
                   wd_be[NUM_PORTS-1:0] : '0;
  // Set wins over clear so an event in the clearing cycle is kept
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | port_evt;
  assign cb_tick = {2'b00, cb_tick_ff};
  assign ext_rise = pin_sync_ff[0] & ~ext_prev_ff;

  always_comb begin
    rd_mux = 32'h0;
    if (avs_address == ADDR_GLOBAL) begin
      rd_mux[GLB_LINK_EN] = link_en_ff;
    end else if (avs_address == ADDR_IRQ_STATUS) begin
      rd_mux[NUM_PORTS-1:0] = irq_stat_ff;
    end else if (avs_address == ADDR_IRQ_MASK) begin
      rd_mux[NUM_PORTS-1:0] = irq_mask_ff;
    end else if (cb_hit) begin
      rd_mux[CB_CFG_W-1:0] = cb_cfg_ff[cb_idx];
    end else if (port_hit) begin
      unique case (a_off)
        POFF_CTRL: rd_mux[CTRL_W-1:0] = ctrl_ff[a_port];
        POFF_DATA: rd_mux = tx_ff[a_port];
        POFF_TIME: rd_mux[CNT_W-1:0] = time_ff[a_port];
        POFF_COND: rd_mux = cond_ff[a_port];
        POFF_COUNT: rd_mux[CNT_W-1:0] = count_ff[a_port];
        POFF_TSTAMP: rd_mux[CNT_W-1:0] = tstamp_ff[a_port];
        POFF_STAT: begin
          rd_mux[STAT_FULL] = tx_full_ff[a_port];
          rd_mux[STAT_BUSY] = (pstate_ff[a_port] == PS_SHIFT);
        end
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // Answer one cycle after the request is seen
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
      readdata_ff <= 32'h0;
    end else begin
      wait_ff <= ~(req & wait_ff);
      if (req && wait_ff) begin
        readdata_ff <= avs_read ? rd_mux : 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_en_ff <= 1'b0;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_acc && avs_address == ADDR_GLOBAL) begin
        link_en_ff <= be_mask[GLB_LINK_EN] ? avs_writedata[GLB_LINK_EN] : link_en_ff;
      end
      if (wr_acc && avs_address == ADDR_IRQ_MASK) begin
        irq_mask_ff <= (irq_mask_ff & ~be_mask[NUM_PORTS-1:0]) | wd_be[NUM_PORTS-1:0];
      end
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Two flip-flops before any logic reads a pin or strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      ext_prev_ff <= 1'b0;
      stb_meta_ff <= '0;
      stb_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
      ext_prev_ff <= pin_sync_ff[0];
      stb_meta_ff <= incoming_valid_strobe;
      stb_sync_ff <= stb_meta_ff;
    end
  end

  // Clock blocks as tick enables on sys_clk
  for (genvar k = 0; k < NUM_CB; k++) begin : g_cb
    if (k == 0) begin : g_ref
      logic [8:0] acc_ff;
      logic [8:0] acc_sum;
      assign acc_sum = acc_ff + REF_ACC_STEP;
      // Fractional step keeps the average rate exact without a second clock
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          acc_ff <= 9'h000;
          cb_tick_ff[k] <= 1'b0;
          cb_cfg_ff[k] <= CB_CFG_RST;
        end else begin
          acc_ff <= (acc_sum >= REF_ACC_MOD) ? acc_sum - REF_ACC_MOD : acc_sum;
          cb_tick_ff[k] <= (acc_sum >= REF_ACC_MOD);
        end
      end
    end else begin : g_div
      logic [7:0] div_cnt_ff;
      logic src_ev;
      logic cfg_wr;
      assign src_ev = cb_cfg_ff[k][CB_SRC_EXT] ? ext_rise : cb_tick_ff[0];
      assign cfg_wr = wr_acc & cb_hit & (cb_idx == 3'(k));
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          div_cnt_ff <= 8'h00;
          cb_tick_ff[k] <= 1'b0;
          cb_cfg_ff[k] <= CB_CFG_RST;
        end else begin
          if (cfg_wr) begin
            cb_cfg_ff[k] <= (cb_cfg_ff[k] & ~be_mask[CB_CFG_W-1:0]) | wd_be[CB_CFG_W-1:0];
          end
          cb_tick_ff[k] <= src_ev && (div_cnt_ff == cb_cfg_ff[k][7:0]);
          if (src_ev) begin
            div_cnt_ff <= (div_cnt_ff == cb_cfg_ff[k][7:0]) ? 8'h00 : div_cnt_ff + 8'h01;
          end
        end
      end
    end
  end

  // One port per width
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam int W = PORT_W[p];
    localparam int NCH = DATA_W / W;
    localparam logic [CHUNK_W-1:0] LAST = CHUNK_W'(NCH - 1);
    localparam logic [PIN_W-1:0] WMASK = PIN_W'((64'd1 << W) - 64'd1);
    logic dir_out, sel_tick, time_hit, cond_hit, stb_ok, wr_here, data_wr, data_rd;
    logic start_out, step_out, in_step, in_done;
    logic [DATA_W-1:0] pins_w, shift_in_val;

    assign port_en[p] = ctrl_ff[p][CTRL_EN];
    assign dir_out = ctrl_ff[p][CTRL_DIR_OUT];
    assign sel_tick = cb_tick[ctrl_ff[p][CTRL_CB_LSB +: CB_SEL_W]];
    assign time_hit = ~ctrl_ff[p][CTRL_TIMED] | (count_ff[p] == time_ff[p]);
    assign pins_w = DATA_W'(pin_sync_ff[W-1:0]);
    assign cond_hit = ~ctrl_ff[p][CTRL_COND_EN]
                      | ((pins_w == cond_ff[p]) ^ ctrl_ff[p][CTRL_COND_NEQ]);
    assign stb_ok = ~ctrl_ff[p][CTRL_STB_IN] | stb_sync_ff[p];
    assign wr_here = wr_acc & port_hit & (a_port == 3'(p));
    assign data_wr = wr_here & (a_off == POFF_DATA) & dir_out;
    assign data_rd = rd_acc & port_hit & (a_port == 3'(p)) & (a_off == POFF_DATA) & ~dir_out;
    assign start_out = port_en[p] & dir_out & sel_tick & (pstate_ff[p] == PS_IDLE)
                       & tx_full_ff[p] & time_hit;
    assign step_out = port_en[p] & dir_out & sel_tick & (pstate_ff[p] == PS_SHIFT);
    assign in_step = port_en[p] & ~dir_out & sel_tick & cond_hit & stb_ok
                     & ((pstate_ff[p] == PS_SHIFT) | time_hit);
    assign in_done = in_step & (chunk_ff[p] == LAST);
    // Newest sample enters at the top, so the first lands in the low bits
    assign shift_in_val = (shift_ff[p] >> W) | (pins_w << (DATA_W - W));
    assign port_evt[p] = start_out | in_done;
    assign port_od_mask[p] = ctrl_ff[p][CTRL_OD] ? WMASK : '0;
    assign drive_oe[p] = (port_en[p] & dir_out) ?
                         (ctrl_ff[p][CTRL_OD] ? (~shift_ff[p] & WMASK) : WMASK) : '0;
    assign drive_val[p] = ctrl_ff[p][CTRL_OD] ? '0 : (shift_ff[p] & WMASK);

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_ff[p] <= CTRL_RST;
        time_ff[p] <= '0;
        cond_ff[p] <= '0;
        count_ff[p] <= '0;
      end else begin
        count_ff[p] <= count_ff[p] + {15'h0, sel_tick};
        if (wr_here && a_off == POFF_CTRL) begin
          ctrl_ff[p] <= (ctrl_ff[p] & ~be_mask[CTRL_W-1:0]) | wd_be[CTRL_W-1:0];
        end
        if (wr_here && a_off == POFF_TIME) begin
          time_ff[p] <= (time_ff[p] & ~be_mask[CNT_W-1:0]) | wd_be[CNT_W-1:0];
        end
        if (wr_here && a_off == POFF_COND) begin
          cond_ff[p] <= merge(cond_ff[p], avs_writedata, be_mask);
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        tx_ff[p] <= '0;
        tx_full_ff[p] <= 1'b0;
        shift_ff[p] <= '0;
        chunk_ff[p] <= '0;
        pstate_ff[p] <= PS_IDLE;
        tstamp_ff[p] <= '0;
        strobe_ff[p] <= 1'b0;
      end else begin
        // Completion wins over a read clearing the flag in the same cycle
        tx_full_ff[p] <= (tx_full_ff[p] & ~start_out & ~data_rd) | in_done | data_wr;
        strobe_ff[p] <= ctrl_ff[p][CTRL_STB_OUT] & (start_out | step_out);
        if (data_wr) begin
          tx_ff[p] <= merge(tx_ff[p], avs_writedata, be_mask);
        end else if (in_done) begin
          tx_ff[p] <= shift_in_val;
        end
        if (start_out) begin
          shift_ff[p] <= tx_ff[p];
          tstamp_ff[p] <= count_ff[p];
          chunk_ff[p] <= '0;
          pstate_ff[p] <= (NCH > 1) ? PS_SHIFT : PS_IDLE;
        end else if (step_out) begin
          shift_ff[p] <= shift_ff[p] >> W;
          chunk_ff[p] <= chunk_ff[p] + 6'h01;
          pstate_ff[p] <= (chunk_ff[p] + 6'h01 == LAST) ? PS_IDLE : PS_SHIFT;
        end else if (in_step) begin
          shift_ff[p] <= shift_in_val;
          chunk_ff[p] <= in_done ? '0 : chunk_ff[p] + 6'h01;
          pstate_ff[p] <= in_done ? PS_IDLE : PS_SHIFT;
          if (in_done) begin
            tstamp_ff[p] <= count_ff[p];
          end
        end
      end
    end
  end

  // Pin ownership: link first, then the narrowest enabled port
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    always_comb begin
      logic found;
      found = 1'b0;
      nxt_pin_out[i] = 1'b0;
      nxt_pin_oe[i] = 1'b0;
      od_mask[i] = 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!found && port_en[p] && PORT_W[p] > i) begin
          found = 1'b1;
          nxt_pin_out[i] = drive_val[p][i];
          nxt_pin_oe[i] = drive_oe[p][i];
          od_mask[i] = port_od_mask[p][i];
        end
      end
      if (link_en_ff && i >= LINK_PIN_LO) begin
        nxt_pin_out[i] = 1'b0;
        nxt_pin_oe[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = wait_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign outgoing_valid_strobe = strobe_ff;
  assign irq = irq_ff;

  AST_BUS_ANSWER : assert property (
    @(posedge sys_clk) disable iff (!rst_n) (req && wait_ff) |=> !wait_ff)
    else $error("bus request not answered in one cycle");
  AST_LINK_FREE : assert property (
    @(posedge sys_clk) disable iff (!rst_n) link_en_ff |=> (pin_oe_ff[31:16] == 16'h0))
    else $error("port drives a pin owned by the link");
  AST_OPEN_DRAIN : assert property (
    @(posedge sys_clk) disable iff (!rst_n) 1'b1 |=> ((pin_out_ff & $past(od_mask)) == 32'h0))
    else $error("open-drain pin driven high");
  AST_COUNT_STEP : assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cb_tick[ctrl_ff[0][5:3]] |=> (count_ff[0] == $past(count_ff[0]) + 16'h1))
    else $error("port counter did not step on its tick");
  AST_IN_STAMP : assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ($rose(tx_full_ff[2]) && !ctrl_ff[2][1] && $past(port_evt[2]))
    |-> (tstamp_ff[2] == $past(count_ff[2])))
    else $error("input timestamp differs from counter");
  AST_NARROW_WINS : assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (port_en[0] && !link_en_ff) |=> (pin_oe_ff[0] == $past(drive_oe[0][0])))
    else $error("narrow port lost its shared pin");
  AST_TIMED_START : assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (port_evt[0] && ctrl_ff[0][CTRL_DIR_OUT] && ctrl_ff[0][CTRL_TIMED])
    |-> (count_ff[0] == time_ff[0]) ##1 (tstamp_ff[0] == $past(time_ff[0])))
    else $error("timed output left at the wrong count");
  AST_INPUT_QUIET : assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (port_en == 5'h04 && !ctrl_ff[2][CTRL_DIR_OUT]) |=> (pin_oe_ff == 32'h0))
    else $error("input port drives its pins");
  AST_STROBE_TICK : assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(strobe_ff[0]) |-> $past(cb_tick[ctrl_ff[0][5:3]]) && $past(ctrl_ff[0][CTRL_STB_OUT]))
    else $error("outgoing strobe without a clock block tick");

endmodule

// ---- bench/pin_partner.sv ----
// External hardware on the port pins: pull-down pins, data drive, strobes, clock bursts.
// Assumes bench controls change by non-blocking assignment just after sys_clk rises.
module pin_partner import timed_io_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Device pins
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe,
  output logic [PIN_W-1:0] pin_in,
  output logic [NUM_PORTS-1:0] incoming_valid_strobe,
  // Bench control
  input wire logic [PIN_W-1:0] ext_val,
  input wire logic [NUM_PORTS-1:0] stb_level,
  input wire logic go,
  input wire logic [7:0] burst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  logic [2:0] phase_ff;
  logic ext_clk;
  // Clock on pin 0 runs only within a burst, still and low otherwise
  assign ext_clk = (left_ff != 8'h00) && phase_ff[2];
  // Pull-down pins: a released pin reads what the far side drives, else low
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val) | {31'h0, ext_clk};
  assign incoming_valid_strobe = stb_level;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= 8'h00;
      phase_ff <= 3'h0;
    end else if (go) begin
      left_ff <= burst;
      phase_ff <= 3'h0;
    end else if (left_ff != 8'h00) begin
      phase_ff <= phase_ff + 3'h1;
      if (phase_ff == 3'h7) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
endmodule

// ---- bench/timed_io_port_unit_bench.sv ----
// Self-checking bench for the timed I/O port unit over Avalon-MM.
// Assumes the pin partner model stands on the pins and strobes.
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); \
  end \
end
module timed_io_port_unit_bench import timed_io_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [PIN_W-1:0] pin_in, pin_out, pin_oe;
  logic [PIN_W-1:0] ext_val = 32'h0;
  logic [NUM_PORTS-1:0] stb_level = 5'h00;
  logic [NUM_PORTS-1:0] in_stb, out_stb;
  logic go = 1'b0;
  logic [7:0] burst = 8'h00;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;
  always #2 sys_clk = ~sys_clk;
  timed_io_port_unit i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .incoming_valid_strobe(in_stb),
    .outgoing_valid_strobe(out_stb), .irq(irq));
  pin_partner i_ext (.sys_clk(sys_clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in), .incoming_valid_strobe(in_stb), .ext_val(ext_val),
    .stb_level(stb_level), .go(go), .burst(burst));
  function automatic logic [7:0] pa(input int p, input logic [4:0] off);
    return ADDR_PORT_BASE + 8'(p * 32) + 8'(off);
  endfunction
  // Request held until waitrequest is sampled low; no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_data);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    `CHK("bus answer", 1'b0, avs_waitrequest)
    rd_data = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Leaves time 1 ns after the edge where the new chunk sits on the pins
  task automatic wait_stb(input int p);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (out_stb[p] !== 1'b1 && n < 400);
    `CHK("strobe", 1'b1, out_stb[p])
    #1;
  endtask
  task automatic t_reset;
    logic [31:0] d;
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd(pa(p, POFF_CTRL), d);
      `CHK("port ctrl", 32'h0, d)
    end
    rd(ADDR_CB_FIRST, d);
    `CHK("clock block cfg", 32'h0, d)
    rd(8'hfc, d);
    `CHK("unmapped read", 32'h0, d)
    `CHK("irq idle", 1'b0, irq)
    $display("test reset done");
  endtask
  task automatic t_count;
    logic [31:0] c0, c1;
    logic [15:0] diff;
    rd(pa(0, POFF_COUNT), c0);
    wait_cy(50);
    rd(pa(0, POFF_COUNT), c1);
    diff = c1[15:0] - c0[15:0];
    // 53 cycles at 100 of 250 ticks
    `CHK("count rate", 1'b1, (diff >= 16'h14 && diff <= 16'h17))
    $display("test count done");
  endtask
  task automatic t_out;
    logic [31:0] c, d;
    logic [15:0] t;
    wr(ADDR_IRQ_MASK, 32'h0);
    rd(pa(0, POFF_COUNT), c);
    t = c[15:0] + 16'h003c;
    wr(pa(0, POFF_TIME), {16'h0, t});
    wr(pa(0, POFF_CTRL), 32'h443);
    wr(pa(0, POFF_DATA), 32'h5555_5555);
    wait_stb(0);
    `CHK("chunk 0", 2'b11, {pin_out[0], pin_oe[0]})
    wait_stb(0);
    `CHK("chunk 1", 2'b01, {pin_out[0], pin_oe[0]})
    rd(pa(0, POFF_TSTAMP), d);
    `CHK("timestamp", {16'h0, t}, d)
    rd(ADDR_IRQ_STATUS, d);
    `CHK("irq status", 1'b1, d[0])
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 32'h1);
    wait_cy(3);
    `CHK("irq on", 1'b1, irq)
    wr(ADDR_IRQ_STATUS, 32'h1);
    wait_cy(3);
    `CHK("irq cleared", 1'b0, irq)
    $display("test output done");
  endtask
  task automatic t_share;
    wr(pa(1, POFF_CTRL), 32'h007);
    wr(pa(1, POFF_DATA), 32'h5555_5555);
    wr(pa(4, POFF_CTRL), 32'h003);
    wr(pa(4, POFF_DATA), 32'hffff_fff0);
    wr(ADDR_GLOBAL, 32'h1);
    wait_cy(200);
    `CHK("low oe", 4'hb, pin_oe[3:0])
    `CHK("low out", 4'h0, pin_out[3:0])
    `CHK("wide out", 12'hfff, pin_out[15:4])
    `CHK("link pins", 16'h0, pin_oe[31:16])
    wr(ADDR_GLOBAL, 32'h0);
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr(pa(p, POFF_CTRL), 32'h0);
    end
    $display("test sharing done");
  endtask
  task automatic t_input;
    logic [31:0] d;
    wr(pa(2, POFF_COND), 32'h5a);
    wr(pa(2, POFF_CTRL), 32'h081);
    wait_cy(60);
    rd(pa(2, POFF_STAT), d);
    `CHK("cond held off", 1'b0, d[STAT_FULL])
    ext_val <= 32'h5a;
    wait_cy(60);
    rd(pa(2, POFF_STAT), d);
    `CHK("cond met", 1'b1, d[STAT_FULL])
    `CHK("input oe", 8'h0, pin_oe[7:0])
    rd(pa(2, POFF_DATA), d);
    `CHK("input word", 32'h5a5a_5a5a, d)
    wr(pa(2, POFF_CTRL), 32'h201);
    wait_cy(30);
    rd(pa(2, POFF_DATA), d);
    wait_cy(60);
    rd(pa(2, POFF_STAT), d);
    `CHK("strobe low", 1'b0, d[STAT_FULL])
    stb_level <= 5'h04;
    wait_cy(60);
    rd(pa(2, POFF_STAT), d);
    `CHK("strobe high", 1'b1, d[STAT_FULL])
    wr(pa(2, POFF_CTRL), 32'h0);
    ext_val <= 32'h0;
    $display("test input done");
  endtask
  task automatic t_ext;
    logic [31:0] c0, c1;
    wr(pa(3, POFF_CTRL), 32'h009);
    for (int dv = 0; dv < 2; dv++) begin
      wr(ADDR_CB_FIRST, 32'h100 | 32'(dv));
      rd(pa(3, POFF_COUNT), c0);
      burst <= 8'h0c;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      wait_cy(110);
      rd(pa(3, POFF_COUNT), c1);
      `CHK("ext ticks", 16'(12 / (dv + 1)), c1[15:0] - c0[15:0])
    end
    $display("test external clock done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_count;
    t_out;
    t_share;
    t_input;
    t_ext;
    wrap_up;
  end
  // Tests take about 1000 cycles; this cuts a hang well beyond that
  initial begin
    #100000;
    mismatches++;
    wrap_up;
  end
endmodule
